// file: core/acs_cal_status.sv
// Functional notes
// RQ1 - Type 0 scope 00: DAC, gain, offset.
// RQ2 - Type 0 other scopes: internal gain/offset only.
// RQ3 - Type 1 scope 00: DAC, system gain, offset.
// RQ4 - Type 1 other scopes: system gain/offset only.
// RQ5 - Readback select 11 returns 16-bit status.
// RQ6 - Status word starts at zero.
// RQ7 - Bits 15, 13..10 zero; bit 4 unused.
// RQ8 - Bit 14 shows conversion or calibration busy.
// RQ9 - Bits 9..8 echo power-down selection.
// RQ10 - Bits 7..6 always read one.
// RQ11 - Bit 5 interface mode, cleared per read.
// RQ12 - Bit 3 shows self or system type.
// RQ13 - Bit 0 set while calibration runs.
// RQ14 - Bits 2..1 echo scope selection.
// RQ15 - Ten host readable and writable coefficients.
// RQ16 - Calibration runs update coefficients themselves.
// RQ17 - Scope selects coefficients for reads, writes.
// RQ18 - Host never interleaves coefficient reads, writes.
// RQ19 - Launch bit starts run, self-clears at end.
// RQ20 - Scope picks ten, two, offset or gain.
// RQ21 - Pointer resets on scope write or end.
// RQ22 - Host sets readback 10 for coefficients.
// RQ23 - Status echoes fields of latest control write.
`include "acs_cfg.svh"
`timescale 1ns/10ps

module acs_cal_status
   import acs_pkg::*;
#(
   parameter int ADC_W  = `ACS_ADC_W,
   parameter int COEF_W = `ACS_COEF_W,
   parameter int DEPTH  = `ACS_COEF_DEPTH
)
(
   // Clock and reset.
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   // Control word write from the serial port.
   input  wire logic              i_ctrl_wr,
   input  wire logic [13:0]       i_ctrl_data,
   // Coefficient write from the serial port.
   input  wire logic              i_coef_wr,
   input  wire logic [COEF_W-1:0] i_coef_wdata,
   // Read cycle request and returned word.
   input  wire logic              i_rd,
   output logic      [15:0]       o_rd_data,
   output logic                   o_rd_valid,
   // Converter side.
   input  wire logic              i_conv_busy,
   input  wire logic [ADC_W-1:0]  i_adc_data,
   // Calibration engine handshake.
   output logic      [1:0]        o_cal_step,
   output logic                   o_cal_step_start,
   output logic                   o_cal_system,
   input  wire logic              i_step_done,
   input  wire logic              i_upd_we,
   input  wire logic [3:0]        i_upd_idx,
   input  wire logic [COEF_W-1:0] i_upd_data,
   // Settings and the busy flag handed to the rest of the unit.
   output logic      [1:0]        o_power_down_sel,
   output logic                   o_iface_mode1,
   output logic                   o_busy
);

   // ****************************************
   // Declarations.
   // ****************************************
   logic [1:0]        power_down_sel_ff;   // Power management field.
   logic [1:0]        readback_sel_ff;     // Read register selection.
   logic              mode_ff;             // Interface variant, 1 = first mode.
   logic              cal_type_select_ff;  // 0 self, 1 system.
   logic [1:0]        cal_scope_ff;        // Scope bits {hi, lo}.
   logic              cal_launch_ff;       // Set while a run is active.
   acs_step_t         step_ff;             // Current calibration step.
   acs_step_t         nxt_step;            // Step after the current one.
   logic              step_start_ff;       // One-cycle pulse per new step.
   logic              busy_ff;             // Registered busy flag.
   logic [3:0]        ptr_ff;              // Coefficient pointer.
   logic [3:0]        ptr_start;           // First index of the sequence.
   logic [3:0]        ptr_end;             // Last index of the sequence.
   logic [15:0]       rd_data_ff;          // Returned read word.
   logic              rd_valid_ff;         // Read word strobe.
   logic [15:0]       status_word;         // Assembled status word.
   logic [COEF_W-1:0] mem_rdata;           // Coefficient at the pointer.
   logic              mem_we;              // Store write enable.
   logic [3:0]        mem_waddr;           // Store write index.
   logic [COEF_W-1:0] mem_wdata;           // Store write data.
   logic              ctrl_take;           // Control write accepted.
   logic              coef_access;         // Host access moves the pointer.
   logic              cal_scope_hi;        // Upper scope bit.
   logic              cal_scope_lo;        // Lower scope bit.

   assign cal_scope_hi = cal_scope_ff[1];
   assign cal_scope_lo = cal_scope_ff[0];

   // A control write during a run is ignored so the run is not disturbed.
   assign ctrl_take = i_ctrl_wr && !cal_launch_ff;

   // ****************************************
   // Control fields.
   // ****************************************

   // Latches the settings of the latest accepted control write.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         power_down_sel_ff  <= 2'h0;
         readback_sel_ff    <= `ACS_RB_ADC;
         cal_type_select_ff <= 1'b0;
         cal_scope_ff       <= `ACS_SCOPE_FULL;
      end
      else if (ctrl_take)
      begin
         // Fields are echoed later in the status word.
         power_down_sel_ff  <= i_ctrl_data[`ACS_CTL_PD_HI:`ACS_CTL_PD_LO]; // RQ23
         readback_sel_ff    <= i_ctrl_data[`ACS_CTL_RB_HI:`ACS_CTL_RB_LO]; // RQ23
         cal_type_select_ff <= i_ctrl_data[`ACS_CTL_TYPE]; // RQ23
         cal_scope_ff       <= i_ctrl_data[`ACS_CTL_SCOPE_HI:`ACS_CTL_SCOPE_LO]; // RQ17
      end
   end

   // Interface variant: set by a write, dropped after every read cycle that has no accepted write in the same cycle.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         mode_ff <= 1'b0;
      end
      else if (ctrl_take)
      begin
         // A write in the same cycle as a read wins, as it is the newer request.
         mode_ff <= i_ctrl_data[`ACS_CTL_MODE];
      end
      else if (i_rd)
      begin
         // Each read cycle falls back to the second mode.
         mode_ff <= 1'b0; // RQ11
      end
   end

   // ****************************************
   // Calibration sequencer.
   // ****************************************

   // Chooses the step that follows the current one.
   always_comb
   begin
      case (step_ff)
         ACS_DAC:
         begin
            // The DAC step is always followed by gain.
            nxt_step = ACS_GAIN; // RQ1 RQ3
         end
         ACS_GAIN:
         begin
            // Full and gain-plus-offset runs go on to offset.
            if ((cal_scope_ff == `ACS_SCOPE_FULL) || (cal_scope_ff == `ACS_SCOPE_GO))
            begin
               nxt_step = ACS_OFFSET; // RQ2 RQ4
            end
            else
            begin
               nxt_step = ACS_IDLE; // RQ2 RQ4
            end
         end
         ACS_OFFSET:
         begin
            // Offset is always the last step.
            nxt_step = ACS_IDLE;
         end
         default:
         begin
            nxt_step = ACS_IDLE;
         end
      endcase
   end

   // Starts a run on a launch write and walks through its steps.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         step_ff       <= ACS_IDLE;
         cal_launch_ff <= 1'b0;
         step_start_ff <= 1'b0;
      end
      else if (ctrl_take && i_ctrl_data[`ACS_CTL_LAUNCH])
      begin
         // The first step depends on the scope just written.
         cal_launch_ff <= 1'b1; // RQ19
         step_start_ff <= 1'b1;
         case (i_ctrl_data[`ACS_CTL_SCOPE_HI:`ACS_CTL_SCOPE_LO])
            `ACS_SCOPE_FULL:
            begin
               step_ff <= ACS_DAC; // RQ1 RQ3
            end
            `ACS_SCOPE_OFS:
            begin
               step_ff <= ACS_OFFSET; // RQ2 RQ4
            end
            default:
            begin
               step_ff <= ACS_GAIN; // RQ2 RQ4
            end
         endcase
      end
      else if ((step_ff != ACS_IDLE) && i_step_done)
      begin
         // The launch flag drops with the end of the last step.
         step_ff       <= nxt_step;
         step_start_ff <= (nxt_step != ACS_IDLE);
         cal_launch_ff <= (nxt_step != ACS_IDLE); // RQ19
      end
      else
      begin
         step_start_ff <= 1'b0;
      end
   end

   // Busy covers both conversions and calibration runs.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         busy_ff <= 1'b0;
      end
      else
      begin
         busy_ff <= i_conv_busy || cal_launch_ff; // RQ8
      end
   end

   // ****************************************
   // Coefficient pointer.
   // ****************************************

   // First and last index of the selected access sequence.
   always_comb
   begin
      case (cal_scope_ff)
         `ACS_SCOPE_FULL:
         begin
            // Gain, offset, then the eight DAC words.
            ptr_start = `ACS_IDX_GAIN; // RQ20
            ptr_end   = `ACS_IDX_DAC_LAST;
         end
         `ACS_SCOPE_GO:
         begin
            // Gain then offset.
            ptr_start = `ACS_IDX_GAIN; // RQ20
            ptr_end   = `ACS_IDX_OFS;
         end
         `ACS_SCOPE_OFS:
         begin
            // Offset alone starts the pointer at offset.
            ptr_start = `ACS_IDX_OFS; // RQ20 RQ21
            ptr_end   = `ACS_IDX_OFS;
         end
         default:
         begin
            // Gain alone.
            ptr_start = `ACS_IDX_GAIN; // RQ20
            ptr_end   = `ACS_IDX_GAIN;
         end
      endcase
   end

   // Host reads move the pointer only when coefficients are selected.
   assign coef_access = (i_coef_wr && !cal_launch_ff) ||
                        (i_rd && (readback_sel_ff == `ACS_RB_COEF)); // RQ22

   // Resets on a control write and wraps after the last access.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ptr_ff <= `ACS_IDX_GAIN;
      end
      else if (ctrl_take)
      begin
         // The reset point follows the newly written scope.
         if (i_ctrl_data[`ACS_CTL_SCOPE_HI:`ACS_CTL_SCOPE_LO] == `ACS_SCOPE_OFS)
         begin
            ptr_ff <= `ACS_IDX_OFS; // RQ21
         end
         else
         begin
            ptr_ff <= `ACS_IDX_GAIN; // RQ21
         end
      end
      else if (coef_access)
      begin
         if (ptr_ff == ptr_end)
         begin
            // The sequence is complete, so start over.
            ptr_ff <= ptr_start; // RQ21
         end
         else
         begin
            ptr_ff <= ptr_ff + 4'h1; // RQ21
         end
      end
   end

   // ****************************************
   // Coefficient store.
   // ****************************************

   // During a run only the engine writes; otherwise only the host.
   always_comb
   begin
      if (cal_launch_ff)
      begin
         mem_we    = i_upd_we; // RQ16
         mem_waddr = i_upd_idx;
         mem_wdata = i_upd_data;
      end
      else
      begin
         mem_we    = i_coef_wr; // RQ15 RQ17
         mem_waddr = ptr_ff;
         mem_wdata = i_coef_wdata;
      end
   end

   // Ten words, read continuously at the pointer.
   acs_coef_mem
   #(
      .W     (COEF_W),
      .DEPTH (DEPTH),
      .AW    (4)
   )
   u_coef_mem
   (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_raddr (ptr_ff), // RQ15 RQ17
      .o_rdata (mem_rdata)
   );

   // ****************************************
   // Readback.
   // ****************************************

   // Status word built from live state and echoed settings.
   assign status_word =
   {
      1'b0,               // Always zero.
      busy_ff,            // RQ8
      4'h0,               // RQ7
      power_down_sel_ff,  // RQ9
      `ACS_STAT_ID,       // RQ10
      mode_ff,            // RQ11
      1'b0,               // Unused bit, reads zero.
      cal_type_select_ff, // RQ12
      cal_scope_hi,       // RQ14
      cal_scope_lo,       // RQ14
      cal_launch_ff       // RQ13
   };

   // Returns the selected register one cycle after each read request.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_data_ff  <= `ACS_STAT_RESET; // RQ6
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= i_rd;
         if (i_rd)
         begin
            case (readback_sel_ff)
               `ACS_RB_ADC:
               begin
                  // Conversion result with four leading zeros.
                  rd_data_ff <= {4'h0, i_adc_data};
               end
               `ACS_RB_COEF:
               begin
                  // Coefficient with two leading zeros.
                  rd_data_ff <= {2'b00, mem_rdata[`ACS_COEF_DATA_W-1:0]}; // RQ15
               end
               `ACS_RB_STATUS:
               begin
                  rd_data_ff <= status_word; // RQ5
               end
               default:
               begin
                  // Test register has no content here.
                  rd_data_ff <= 16'h0000;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Outputs.
   // ****************************************
   assign o_rd_data        = rd_data_ff;
   assign o_rd_valid       = rd_valid_ff;
   assign o_cal_step       = step_ff;
   assign o_cal_step_start = step_start_ff;
   assign o_cal_system     = cal_type_select_ff;
   assign o_power_down_sel = power_down_sel_ff;
   assign o_iface_mode1    = mode_ff;
   assign o_busy           = busy_ff;

endmodule // acs_cal_status

// file: core/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ****************************************
// Control word layout (14 bits).
// ****************************************
`define ACS_CTL_W        14
`define ACS_CTL_LAUNCH   0
`define ACS_CTL_SCOPE_LO 1
`define ACS_CTL_SCOPE_HI 2
`define ACS_CTL_TYPE     3
`define ACS_CTL_MODE     5
`define ACS_CTL_RB_LO    6
`define ACS_CTL_RB_HI    7
`define ACS_CTL_PD_LO    8
`define ACS_CTL_PD_HI    9

// ****************************************
// Status word layout and reset value.
// ****************************************
`define ACS_STAT_W       16
`define ACS_STAT_RESET   16'h0000
`define ACS_STAT_BUSY    14
`define ACS_STAT_ID      2'h3

// ****************************************
// Readback selection codes.
// ****************************************
`define ACS_RB_ADC       2'h0
`define ACS_RB_TEST      2'h1
`define ACS_RB_COEF      2'h2
`define ACS_RB_STATUS    2'h3

// ****************************************
// Scope codes and coefficient indices.
// ****************************************
`define ACS_SCOPE_FULL   2'h0
`define ACS_SCOPE_GO     2'h1
`define ACS_SCOPE_OFS    2'h2
`define ACS_SCOPE_GAIN   2'h3
`define ACS_IDX_GAIN     4'h0
`define ACS_IDX_OFS      4'h1
`define ACS_IDX_DAC_LAST 4'h9
`define ACS_COEF_DEPTH   10
`define ACS_COEF_W       16
`define ACS_COEF_DATA_W  14
`define ACS_ADC_W        12

`endif

// file: core/acs_coef_mem.sv
`timescale 1ns/10ps

// ****************************************
// Coefficient store, one write port and a registered read port.
// ****************************************
module acs_coef_mem
#(
   parameter int W     = 16,
   parameter int DEPTH = 10,
   parameter int AW    = 4
)
(
   // Clock and reset.
   input  wire logic          i_clock,
   input  wire logic          i_rst,
   // Write port.
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [W-1:0]  i_wdata,
   // Read port.
   input  wire logic [AW-1:0] i_raddr,
   output logic      [W-1:0]  o_rdata
);

   logic [W-1:0] mem_ff [DEPTH];  // Storage words.
   logic [W-1:0] rdata_ff;        // Registered read data.

   // Writes beyond the last word are dropped.
   always_ff @(posedge i_clock)
   begin
      if (i_we && (int'(i_waddr) < DEPTH))
      begin
         mem_ff[i_waddr] <= i_wdata;
      end
   end

   // The read word follows the address one cycle later.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_ff <= '0;
      end
      else if (int'(i_raddr) < DEPTH)
      begin
         rdata_ff <= mem_ff[i_raddr];
      end
      else
      begin
         rdata_ff <= '0;
      end
   end

   assign o_rdata = rdata_ff;

endmodule // acs_coef_mem

// file: core/acs_pkg.sv
package acs_pkg;

   // Calibration step being carried out by the sequencer.
   typedef enum logic [1:0]
   {
      ACS_IDLE,
      ACS_DAC,
      ACS_GAIN,
      ACS_OFFSET
   } acs_step_t;

endpackage

// file: sim/acs_cal_engine_model.sv
`timescale 1ns/10ps

// ****************************************
// Calibration engine stand-in, prompt or slow.
// ****************************************
module acs_cal_engine_model
   import acs_pkg::*;
(
   // Clock, reset and pace.
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_slow,
   // Step request from the block.
   input  wire logic [1:0] i_step,
   input  wire logic       i_start,
   // Step answer and coefficient update.
   output logic            o_done,
   output logic            o_upd_we,
   output logic [3:0]      o_upd_idx,
   output logic [15:0]     o_upd_data
);
   logic [3:0] cnt_ff;   // Cycles left in the current step.
   logic [3:0] nxt_idx;  // Coefficient that the step updates.

   assign nxt_idx = (i_step == ACS_DAC) ? 4'h2 : (i_step == ACS_GAIN) ? 4'h0 : 4'h1;

   // Counts out a step, writes its coefficient, then ends the step.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_ff     <= 4'h0;
         o_done     <= 1'b0;
         o_upd_we   <= 1'b0;
         o_upd_idx  <= 4'h0;
         o_upd_data <= 16'h0000;
      end
      else
      begin
         cnt_ff     <= i_start ? (i_slow ? 4'h8 : 4'h2) : (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0;
         o_done     <= cnt_ff == 4'h1;
         o_upd_we   <= cnt_ff == 4'h2;
         o_upd_idx  <= nxt_idx;
         // Outside a write the data toggles, so nothing stale looks valid.
         o_upd_data <= (cnt_ff == 4'h2) ? {12'h123, nxt_idx} : ~o_upd_data;
      end
   end
endmodule // acs_cal_engine_model

// file: sim/acs_cal_status_chk.sv
`timescale 1ns/10ps

// ****************************************
// Port checker of the calibration status block.
// ****************************************
module acs_cal_status_chk
   import acs_pkg::*;
(
   // Clock and reset.
   input wire logic        i_clock,
   input wire logic        i_rst,
   // Host side.
   input wire logic        i_ctrl_wr,
   input wire logic [13:0] i_ctrl_data,
   input wire logic        i_rd,
   input wire logic [15:0] o_rd_data,
   input wire logic        o_rd_valid,
   // Engine side.
   input wire logic [1:0]  o_cal_step,
   input wire logic        o_cal_step_start,
   input wire logic        i_step_done,
   input wire logic        o_busy
);
   logic [1:0] rb_ff;  // Accepted readback select.
   logic [1:0] sc_ff;  // Accepted scope.
   logic [1:0] pd_ff;  // Accepted power select.
   logic       ty_ff;  // Accepted calibration type.
   logic       ok_wr;  // A control write that the block takes.
   logic       st_rd;  // The status word is on the read port.

   // Only a running calibration refuses a write; a conversion does not.
   assign ok_wr = i_ctrl_wr && o_cal_step == ACS_IDLE;
   assign st_rd = o_rd_valid && rb_ff == 2'h3;

   // Shadows the fields of each accepted control write.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rb_ff <= 2'h0;
         sc_ff <= 2'h0;
         pd_ff <= 2'h0;
         ty_ff <= 1'b0;
      end
      else if (ok_wr)
      begin
         rb_ff <= i_ctrl_data[7:6];
         sc_ff <= i_ctrl_data[2:1];
         pd_ff <= i_ctrl_data[9:8];
         ty_ff <= i_ctrl_data[3];
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   rd_answer_a: assert property (i_rd |=> o_rd_valid)
      else $error("read request got no answer");
   no_spur_a: assert property (!i_rd |=> !o_rd_valid)
      else $error("read answer without request");
   stat_zero_a: assert property (st_rd |-> !o_rd_data[15] && o_rd_data[13:10] == 4'h0)
      else $error("status zero bits set");
   stat_id_a: assert property (st_rd |-> o_rd_data[7:6] == 2'h3)
      else $error("status marker bits wrong");
   stat_echo_a: assert property (st_rd |-> o_rd_data[9:8] == pd_ff && o_rd_data[3:1] == {ty_ff, sc_ff})
      else $error("status echo wrong");
   coef_lead_a: assert property (o_rd_valid && rb_ff == 2'h2 |-> o_rd_data[15:14] == 2'h0)
      else $error("coefficient leading bits set");
   first_step_a: assert property (ok_wr && i_ctrl_data[0] |=> o_cal_step_start && o_cal_step == ((sc_ff == 2'h0) ? ACS_DAC : (sc_ff == 2'h2) ? ACS_OFFSET : ACS_GAIN) ##1 o_busy)
      else $error("run began with wrong step");
   dac_next_a: assert property (i_step_done && o_cal_step == ACS_DAC |=> o_cal_step == ACS_GAIN)
      else $error("step after converter step wrong");
   gain_next_a: assert property (i_step_done && o_cal_step == ACS_GAIN |=> o_cal_step == ((sc_ff == 2'h3) ? ACS_IDLE : ACS_OFFSET))
      else $error("step after gain step wrong");
endmodule // acs_cal_status_chk

bind acs_cal_status acs_cal_status_chk i_chk
(
   .i_clock, .i_rst, .i_ctrl_wr, .i_ctrl_data, .i_rd, .o_rd_data, .o_rd_valid,
   .o_cal_step, .o_cal_step_start, .i_step_done, .o_busy
);

// file: sim/adc_calibration_status_control_tb_top.sv
`timescale 1ns/10ps

module adc_calibration_status_control_tb_top
   import acs_pkg::*;
;
   // ****************************************
   // Design ports, bench state.
   // ****************************************
   logic        i_clock = 1'b0, i_rst = 1'b1, i_ctrl_wr = 1'b0, i_coef_wr = 1'b0;
   logic        i_rd = 1'b0, i_conv_busy = 1'b0, slow = 1'b0;
   logic [13:0] i_ctrl_data = 14'h0000;
   logic [15:0] i_coef_wdata = 16'h0000;
   logic [11:0] i_adc_data = 12'h000;
   logic [15:0] o_rd_data, i_upd_data;
   logic [1:0]  o_cal_step, o_power_down_sel;
   logic [3:0]  i_upd_idx;
   logic        o_rd_valid, o_cal_step_start, o_cal_system, i_step_done;
   logic        i_upd_we, o_iface_mode1, o_busy, ty;
   logic [1:0]  sc;
   logic [15:0] rq[$];   // Expected read words, oldest first.
   logic [15:0] sq[$];   // Expected calibration steps, oldest first.
   logic [15:0] cw[10];  // Coefficients that the host wrote.
   int          seed = 78116, err_count = 0, n_tests = 0, cycles = 0, k, j, s;

   always #50 i_clock = ~i_clock;

   acs_cal_status i_dut (.i_clock, .i_rst, .i_ctrl_wr, .i_ctrl_data, .i_coef_wr, .i_coef_wdata,
      .i_rd, .o_rd_data, .o_rd_valid, .i_conv_busy, .i_adc_data, .o_cal_step, .o_cal_step_start,
      .o_cal_system, .i_step_done, .i_upd_we, .i_upd_idx, .i_upd_data, .o_power_down_sel,
      .o_iface_mode1, .o_busy);
   acs_cal_engine_model i_eng (.i_clock, .i_rst, .i_slow(slow), .i_step(o_cal_step),
      .i_start(o_cal_step_start), .o_done(i_step_done), .o_upd_we(i_upd_we),
      .o_upd_idx(i_upd_idx), .o_upd_data(i_upd_data));

   // Counts one comparison and reports a mismatch.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One control write, then a settling gap.
   task automatic wr_ctrl(input logic [13:0] d);
      i_ctrl_wr = 1'b1;
      i_ctrl_data = d;
      @(negedge i_clock);
      i_ctrl_wr = 1'b0;
      repeat (2) @(negedge i_clock);
   endtask

   // One coefficient write.
   task automatic wr_coef(input logic [15:0] d);
      i_coef_wr = 1'b1;
      i_coef_wdata = d;
      @(negedge i_clock);
      i_coef_wr = 1'b0;
      @(negedge i_clock);
   endtask

   // One read request; the watcher compares the answer.
   task automatic rd_word(input logic [15:0] exp);
      i_rd = 1'b1;
      rq.push_back(exp);
      @(negedge i_clock);
      i_rd = 1'b0;
      repeat (2) @(negedge i_clock);
   endtask

   // Notes the steps that a run of type t and scope s2 must visit.
   task automatic note_steps(input logic t, input logic [1:0] s2);
      if (s2 == 2'h0)
         sq.push_back({13'h0, t, 2'h1});
      if (s2 != 2'h2)
         sq.push_back({13'h0, t, 2'h2});
      if (s2 != 2'h3)
         sq.push_back({13'h0, t, 2'h3});
   endtask

   // Watcher: takes the oldest note whenever a result appears.
   always @(negedge i_clock)
   begin
      if (o_rd_valid === 1'b1)
         chk("read word", rq.pop_front(), o_rd_data);
      if (o_cal_step_start === 1'b1)
         chk("calibration step", sq.pop_front(), {13'h0, o_cal_system, o_cal_step});
   end

   // Cuts a hung run short.
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         close_out();
      end
   end

   initial
   begin
      i_adc_data = 12'($random(seed));
      repeat (5) @(negedge i_clock);
      i_rst = 1'b0;
      @(negedge i_clock);
      chk("read word at reset", 16'h0000, o_rd_data);
      wr_ctrl(14'h3E0);
      chk("interface mode", 16'h0001, {15'h0, o_iface_mode1});
      chk("power select", 16'h0003, {14'h0, o_power_down_sel});
      i_conv_busy = 1'b1;
      repeat (2) @(negedge i_clock);
      rd_word(16'h43E0);
      i_conv_busy = 1'b0;
      repeat (2) @(negedge i_clock);
      rd_word(16'h03C0);
      wr_ctrl(14'h000);
      rd_word({4'h0, i_adc_data});
      wr_ctrl(14'h040);
      rd_word(16'h0000);
      $display("test status fields done");
      wr_ctrl(14'h000);
      for (k = 0; k < 10; k++)
      begin
         cw[k] = 16'($random(seed));
         wr_coef(cw[k]);
      end
      cw[1] = 16'($random(seed));
      wr_ctrl(14'h004);
      wr_coef(cw[1]);
      for (s = 0; s < 4; s++)
      begin
         // Readback select 10 sits in bits 7:6, power select 10 in bits 9:8.
         wr_ctrl({4'h0, 2'h2, 2'h2, 3'h0, 2'(s), 1'b0});
         for (j = 0; j < ((s == 0) ? 11 : 3); j++)
            rd_word({2'h0, cw[(s == 0) ? j % 10 : (s == 1) ? j % 2 : (s == 2) ? 1 : 0][13:0]});
      end
      $display("test coefficient access done");
      for (k = 0; k < 8; k++)
      begin
         ty = k[2];
         sc = 2'(k);
         slow = k[0] ^ k[2];
         note_steps(ty, sc);
         wr_ctrl({8'h07, 1'b1, 1'b0, ty, sc, 1'b1});
         if (slow)
         begin
            wr_ctrl(14'h2C0);
            rd_word({2'h1, 4'h0, 2'h1, 2'h3, 1'b1, 1'b0, ty, sc, 1'b1});
         end
         for (j = 0; j < 100 && o_busy !== 1'b0; j++)
            @(negedge i_clock);
         repeat (2) @(negedge i_clock);
         rd_word({6'h00, 2'h1, 2'h3, !slow, 1'b0, ty, sc, 1'b0});
      end
      $display("test calibration runs done");
      wr_ctrl(14'h080);
      rd_word(16'h1230);
      rd_word(16'h1231);
      rd_word(16'h1232);
      repeat (4) @(negedge i_clock);
      chk("steps left", 16'h0000, 16'(sq.size()));
      chk("reads left", 16'h0000, 16'(rq.size()));
      $display("test engine updates done");
      close_out();
   end
endmodule // adc_calibration_status_control_tb_top
